//--- inc/rtc_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants and types for the real-time clock with an I2C slave port.
// ----------------------------------------------------------------------------
package rtc_pkg;

    // Own 7-bit bus address of the device; the value is arbitrary.
    localparam logic [6:0] SLAVE_ADDR = 7'h32;

    // Register indexes as seen over the serial bus.
    localparam logic [3:0] IDX_SEC = 4'h0;
    localparam logic [3:0] IDX_MIN = 4'h1;
    localparam logic [3:0] IDX_HOUR = 4'h2;
    localparam logic [3:0] IDX_ALARM0 = 4'h3;
    localparam logic [3:0] IDX_TIMER0 = 4'h6;
    localparam logic [3:0] IDX_EXT = 4'h8;
    localparam logic [3:0] IDX_FLAG = 4'h9;
    localparam logic [3:0] IDX_CTRL = 4'ha;
    localparam logic [3:0] IDX_IOCUT = 4'hb;
    localparam int REG_COUNT = 12;
    localparam logic [3:0] IDX_LAST = 4'hb;

    // Field positions.
    localparam int EXT_TMR_EN_BIT = 4;
    localparam int EXT_TEST_BIT = 7;
    localparam int FLAG_LOSS_BIT = 1;
    localparam int CTRL_STOP_BIT = 0;
    localparam int CTRL_ALM_EN_BIT = 3;
    localparam int CTRL_TMR_EN_BIT = 4;
    localparam int CTRL_UPD_EN_BIT = 5;
    localparam int IOCUT_EN_BIT = 4;

    // Values after reset.
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic LOSS_RESET = 1'b1;

    // Time limits in BCD.
    localparam logic [7:0] SEC_MAX = 8'h59;
    localparam logic [7:0] MIN_MAX = 8'h59;
    localparam logic [7:0] HOUR_MAX = 8'h23;

    // Crystal-derived tick arrives at 1024 Hz; one second ends on the tick that finds this count.
    localparam logic [9:0] PRESC_LAST = 10'h3ff;

    // Bit count of one serial byte.
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // APB byte offsets.
    localparam logic [11:0] APB_STATUS = 12'h000;
    localparam logic [11:0] APB_CMD = 12'h004;
    localparam logic [11:0] APB_TIME = 12'h008;
    localparam int CMD_SWRST_BIT = 0;

    typedef struct packed {
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } time_s;

    typedef struct packed {
        logic xfer_busy;
        logic carry_pending;
        logic stop;
        logic osc_running;
        logic osc_loss_flag;
    } status_s;

endpackage : rtc_pkg

//--- design/rtc_i2c_core.sv
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Function
// [RULE_01] Host writes every reserved bit with its fixed value at initialization.
// [RULE_02] Oscillation-loss flag stays 1 despite clearing writes until oscillation runs.
// [RULE_03] Host programs backup I/O cut enable only after oscillation has started.
// [RULE_04] Host writes alarm, timer and update interrupt enables as 0 at initialization.
// [RULE_05] Host writes the test bit and periodic timer enable as 0.
// [RULE_06] Alarm registers serve as plain storage when the alarm is unused.
// [RULE_07] Timer counter registers serve as plain storage when the timer is unused.
// [RULE_08] Host writes the stop bit 0 at the end of initialization.
// [RULE_09] Host waits 40ms after supply rise and clears the loss flag later.
// [RULE_10] Host performs a dummy read when power-on reset conditions failed.
// [RULE_11] A software reset sets the oscillation-loss flag to 1 again.
// [RULE_12] Stop bit 1 suspends counting; writing 0 resumes from the written values.
// [RULE_13] Writing seconds without the stop bit restarts the clock at that moment.
// [RULE_14] During a transfer the time is frozen; held carries apply at its end.
// [RULE_15] Host should access clock registers in one auto-increment burst.
// [RULE_16] Host completes each transfer from START to STOP within 0.95 seconds.
// [RULE_17] Both lines are left released high when no transfer runs.
// [RULE_18] After START, data moves in 8-bit units with no byte limit.
// [RULE_19] START is SDA falling with SCL high; STOP is SDA rising with SCL high.
// [RULE_20] A START before any STOP is taken as a repeated START.
// [RULE_21] The first byte after START holds the slave address and direction.
// [RULE_22] Only a matching address is answered; otherwise the bus is ignored.
// [RULE_23] SCL and SDA are only pulled low or released, forming a wired-AND.
// [RULE_24] Each byte is followed by a ninth clock carrying acknowledge.
module rtc_i2c_core (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic osc_running,
    input wire logic osc_tick,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    typedef enum logic [2:0] {S_IDLE, S_RX, S_RX_ACK, S_TX, S_TX_ACK} bus_state_e;

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------
    // BCD increment with wrap at a limit; bit 8 reports the wrap as carry.
    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] maxv);
        logic [8:0] r;
        if (v == maxv)
            r = {1'b1, 8'h00};
        else if (v[3:0] == 4'h9)
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        else
            r = {1'b0, v[7:4], v[3:0] + 4'h1};
        return r;
    endfunction : bcd_inc

    // Register pointer auto-increment, cyclic over the implemented map.
    function automatic logic [3:0] ptr_inc(input logic [3:0] p);
        logic [3:0] r;
        r = (p >= rtc_pkg::IDX_LAST) ? 4'h0 : p + 4'h1;
        return r;
    endfunction : ptr_inc

    logic [7:0] regs [rtc_pkg::REG_COUNT];
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic osc_m, osc_run_s, tick_m, tick_s, tick_d;
    bus_state_e st_reg;
    logic [7:0] shift_reg;
    logic [3:0] bitcnt_reg;
    logic [3:0] ptr_reg;
    logic first_reg, ptr_load_reg, rw_reg, ack_ok_reg, busy_reg;
    logic wr_en_reg;
    logic [3:0] wr_idx_reg;
    logic [7:0] wr_data_reg;
    logic loss_reg, swrst_reg, adv_reg, pend_reg;
    logic [9:0] presc_reg;
    logic [7:0] rd_byte;
    logic scl_rise, scl_fall, start_det, stop_det, tick_rise, stop_bit, sec_wr;
    logic [8:0] sec_n, min_n, hour_n;

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    // Every pin passes two flops; a third stage gives the previous value for edges.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {scl_m, scl_s, scl_d} <= 3'b111;
            {sda_m, sda_s, sda_d} <= 3'b111;
            {osc_m, osc_run_s} <= 2'b00;
            {tick_m, tick_s, tick_d} <= 3'b000;
        end
        else if (ce)
        begin
            {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
            {osc_m, osc_run_s} <= {osc_running, osc_m};
            {tick_m, tick_s, tick_d} <= {osc_tick, tick_m, tick_s};
        end
    end

    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s; // [RULE_19]
    assign stop_det = scl_s & scl_d & ~sda_d & sda_s; // [RULE_19]
    assign tick_rise = tick_s & ~tick_d;
    assign stop_bit = regs[rtc_pkg::IDX_CTRL][rtc_pkg::CTRL_STOP_BIT];
    assign sec_wr = wr_en_reg && (wr_idx_reg == rtc_pkg::IDX_SEC);

    // Read view of the register map; the flag register shows the live loss flag.
    always_comb
    begin
        rd_byte = 8'h00;
        if (ptr_reg <= rtc_pkg::IDX_LAST)
            rd_byte = regs[ptr_reg];
        if (ptr_reg == rtc_pkg::IDX_FLAG)
            rd_byte[rtc_pkg::FLAG_LOSS_BIT] = loss_reg;
    end

    // ------------------------------------------------------------------------
    // Serial slave
    // ------------------------------------------------------------------------
    // Bit engine: shifts in on SCL rise, shifts out and changes SDA only on SCL fall.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= S_IDLE;
            shift_reg <= 8'h00;
            bitcnt_reg <= 4'h0;
            ptr_reg <= 4'h0;
            first_reg <= 1'b0;
            ptr_load_reg <= 1'b0;
            rw_reg <= 1'b0;
            ack_ok_reg <= 1'b0;
            sda_oe <= 1'b0;
            wr_en_reg <= 1'b0;
            wr_idx_reg <= 4'h0;
            wr_data_reg <= 8'h00;
            sda_out <= 1'b0;
        end
        else if (ce)
        begin
            wr_en_reg <= 1'b0;
            // The device never drives a high level, it only pulls low.
            sda_out <= 1'b0; // [RULE_23]
            if (start_det)
            begin
                // A START in any state, repeated or not, opens an address byte.
                st_reg <= S_RX; // [RULE_20] [RULE_21]
                bitcnt_reg <= 4'h0;
                first_reg <= 1'b1;
                sda_oe <= 1'b0;
            end
            else if (stop_det)
            begin
                st_reg <= S_IDLE; // [RULE_17]
                sda_oe <= 1'b0;
            end
            else
            begin
                unique case (st_reg)
                    S_IDLE:
                    begin
                        sda_oe <= 1'b0; // [RULE_17]
                    end
                    S_RX:
                    begin
                        if (scl_rise)
                        begin
                            shift_reg <= {shift_reg[6:0], sda_s};
                            bitcnt_reg <= bitcnt_reg + 4'h1;
                        end
                        else if (scl_fall && bitcnt_reg == rtc_pkg::BYTE_BITS) // [RULE_18]
                        begin
                            bitcnt_reg <= 4'h0;
                            if (first_reg)
                            begin
                                first_reg <= 1'b0;
                                if (shift_reg[7:1] == rtc_pkg::SLAVE_ADDR) // [RULE_22]
                                begin
                                    rw_reg <= shift_reg[0]; // [RULE_21]
                                    ptr_load_reg <= ~shift_reg[0];
                                    sda_oe <= 1'b1; // [RULE_24]
                                    st_reg <= S_RX_ACK;
                                end
                                else
                                    st_reg <= S_IDLE; // [RULE_22]
                            end
                            else
                            begin
                                sda_oe <= 1'b1; // [RULE_24]
                                st_reg <= S_RX_ACK;
                                if (ptr_load_reg)
                                begin
                                    ptr_reg <= shift_reg[3:0];
                                    ptr_load_reg <= 1'b0;
                                end
                                else
                                begin
                                    wr_en_reg <= 1'b1;
                                    wr_idx_reg <= ptr_reg;
                                    wr_data_reg <= shift_reg;
                                    ptr_reg <= ptr_inc(ptr_reg);
                                end
                            end
                        end
                    end
                    S_RX_ACK, S_TX_ACK:
                    begin
                        if (scl_rise && st_reg == S_TX_ACK)
                            ack_ok_reg <= ~sda_s; // [RULE_24]
                        else if (scl_fall)
                        begin
                            if (st_reg == S_RX_ACK && !rw_reg)
                            begin
                                sda_oe <= 1'b0;
                                st_reg <= S_RX;
                            end
                            else if (st_reg == S_RX_ACK || ack_ok_reg)
                            begin
                                // Load the next byte and put its first bit out now.
                                shift_reg <= rd_byte;
                                ptr_reg <= ptr_inc(ptr_reg);
                                sda_oe <= ~rd_byte[7]; // [RULE_23]
                                st_reg <= S_TX;
                            end
                            else
                            begin
                                sda_oe <= 1'b0;
                                st_reg <= S_IDLE;
                            end
                        end
                    end
                    S_TX:
                    begin
                        if (scl_rise)
                            bitcnt_reg <= bitcnt_reg + 4'h1;
                        else if (scl_fall)
                        begin
                            if (bitcnt_reg == rtc_pkg::BYTE_BITS) // [RULE_18]
                            begin
                                bitcnt_reg <= 4'h0;
                                sda_oe <= 1'b0;
                                st_reg <= S_TX_ACK;
                            end
                            else
                            begin
                                shift_reg <= {shift_reg[6:0], 1'b0};
                                sda_oe <= ~shift_reg[6]; // [RULE_23]
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Transfer window from START to STOP; freezes the visible time.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            busy_reg <= 1'b0;
        else if (ce)
        begin
            if (start_det)
                busy_reg <= 1'b1; // [RULE_14]
            else if (stop_det)
                busy_reg <= 1'b0; // [RULE_14]
        end
    end

    // ------------------------------------------------------------------------
    // Timekeeping
    // ------------------------------------------------------------------------
    // One second carry is held while busy; transfers are short enough for one.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            presc_reg <= 10'h000;
            pend_reg <= 1'b0;
            adv_reg <= 1'b0;
        end
        else if (ce)
        begin
            adv_reg <= 1'b0;
            if (swrst_reg || sec_wr)
            begin
                presc_reg <= 10'h000; // [RULE_13]
                pend_reg <= 1'b0;
            end
            else if (stop_bit)
                presc_reg <= 10'h000; // [RULE_12]
            else if (pend_reg && !busy_reg)
            begin
                adv_reg <= 1'b1; // [RULE_14]
                pend_reg <= 1'b0;
            end
            else if (tick_rise)
            begin
                presc_reg <= presc_reg + 10'h001;
                if (presc_reg == rtc_pkg::PRESC_LAST)
                begin
                    if (busy_reg)
                        pend_reg <= 1'b1; // [RULE_14]
                    else
                        adv_reg <= 1'b1;
                end
            end
        end
    end

    assign sec_n = bcd_inc(regs[rtc_pkg::IDX_SEC], rtc_pkg::SEC_MAX);
    assign min_n = bcd_inc(regs[rtc_pkg::IDX_MIN], rtc_pkg::MIN_MAX);
    assign hour_n = bcd_inc(regs[rtc_pkg::IDX_HOUR], rtc_pkg::HOUR_MAX);

    // Register file: software reset, then bus writes, then the second advance.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < rtc_pkg::REG_COUNT; i++)
                regs[i] <= rtc_pkg::REG_RESET;
        end
        else if (ce)
        begin
            if (swrst_reg)
            begin
                for (int i = 0; i < rtc_pkg::REG_COUNT; i++)
                    regs[i] <= rtc_pkg::REG_RESET;
            end
            else if (wr_en_reg && wr_idx_reg <= rtc_pkg::IDX_LAST)
                regs[wr_idx_reg] <= wr_data_reg; // [RULE_06] [RULE_07] [RULE_12]
            else if (adv_reg && !stop_bit && !busy_reg)
            begin
                regs[rtc_pkg::IDX_SEC] <= sec_n[7:0];
                if (sec_n[8])
                    regs[rtc_pkg::IDX_MIN] <= min_n[7:0];
                if (sec_n[8] && min_n[8])
                    regs[rtc_pkg::IDX_HOUR] <= hour_n[7:0];
            end
            // Without oscillation the I/O cut enable cannot hold a 1.
            if (!osc_run_s)
                regs[rtc_pkg::IDX_IOCUT][rtc_pkg::IOCUT_EN_BIT] <= 1'b0; // [RULE_03]
        end
    end

    // Loss flag: setting by a stopped crystal or reset wins over a clearing write.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            loss_reg <= rtc_pkg::LOSS_RESET;
        else if (ce)
        begin
            if (swrst_reg)
                loss_reg <= 1'b1; // [RULE_11]
            else if (!osc_run_s)
                loss_reg <= 1'b1; // [RULE_02]
            else if (wr_en_reg && wr_idx_reg == rtc_pkg::IDX_FLAG
                     && !wr_data_reg[rtc_pkg::FLAG_LOSS_BIT])
                loss_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------
    // One wait state: pready rises in the second access cycle, data registered.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            swrst_reg <= 1'b0;
        end
        else if (ce)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            swrst_reg <= 1'b0;
            if (psel && penable && !pready)
            begin
                pready <= 1'b1;
                prdata <= 32'h0000_0000;
                unique case (paddr)
                    rtc_pkg::APB_STATUS:
                        prdata <= {27'h0, rtc_pkg::status_s'({busy_reg, pend_reg, stop_bit,
                                                              osc_run_s, loss_reg})};
                    rtc_pkg::APB_TIME:
                        prdata <= {8'h00, rtc_pkg::time_s'({regs[rtc_pkg::IDX_HOUR],
                                   regs[rtc_pkg::IDX_MIN], regs[rtc_pkg::IDX_SEC]})};
                    rtc_pkg::APB_CMD:
                        swrst_reg <= pwrite & pwdata[rtc_pkg::CMD_SWRST_BIT];
                    default:
                        pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_loss_hold;
        ce && !osc_run_s |=> loss_reg;
    endproperty
    a_loss_hold: assert property (p_loss_hold) else $error("loss flag cleared early"); // [RULE_02]

    property p_swrst_loss;
        ce && swrst_reg |=> loss_reg && regs[rtc_pkg::IDX_CTRL] == rtc_pkg::REG_RESET;
    endproperty
    a_swrst_loss: assert property (p_swrst_loss) else $error("reset left flag low"); // [RULE_11]

    property p_stop_hold;
        ce && stop_bit && !wr_en_reg && !swrst_reg |=> $stable(regs[rtc_pkg::IDX_SEC]);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("time moved while stopped"); // [RULE_12]

    property p_sec_restart;
        ce && sec_wr |=> presc_reg == 10'h000 && !pend_reg;
    endproperty
    a_sec_restart: assert property (p_sec_restart) else $error("seconds write kept phase"); // [RULE_13]

    property p_freeze;
        ce && busy_reg && !wr_en_reg && !swrst_reg |=> $stable(regs[rtc_pkg::IDX_SEC]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("time moved during transfer"); // [RULE_14]

    property p_apply;
        ce && pend_reg && !busy_reg && !stop_bit && !swrst_reg && !sec_wr
            |=> adv_reg && !pend_reg;
    endproperty
    a_apply: assert property (p_apply) else $error("held carry not applied"); // [RULE_14]

    property p_idle_release;
        ce && st_reg == S_IDLE && !start_det |=> !sda_oe;
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("sda held when idle"); // [RULE_17]

    property p_start_busy;
        ce && start_det |=> busy_reg && st_reg == S_RX && bitcnt_reg == 4'h0;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start not taken"); // [RULE_20]

    property p_addr_ack;
        ce && st_reg == S_RX && first_reg && scl_fall && bitcnt_reg == rtc_pkg::BYTE_BITS
            && !start_det && !stop_det |=> sda_oe == (shift_reg[7:1] == rtc_pkg::SLAVE_ADDR);
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address answer wrong"); // [RULE_22]

    property p_bitcnt;
        bitcnt_reg <= rtc_pkg::BYTE_BITS;
    endproperty
    a_bitcnt: assert property (p_bitcnt) else $error("byte over eight bits"); // [RULE_18]

endmodule : rtc_i2c_core

//--- tb/i2c_host_model.sv
`timescale 1ns/1ps
// ----
// Serial bus host model
// ----
module i2c_host_model (
    input wire logic core_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    // Both lines start released, so the pull-ups hold them high.
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Half of the 48 ns link period.
    task automatic half;
        repeat (6) @(posedge core_clk);
    endtask : half

    // Data falls while the clock is high; also used as a repeated START.
    task automatic start;
        sda_pull <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_pull <= 1'b1;
        half();
        scl <= 1'b0;
        half();
    endtask : start

    // Data rises while the clock is high, then both lines stay released.
    task automatic stop;
        sda_pull <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_pull <= 1'b0;
        half();
    endtask : stop

    // Eight bits MSB first and the acknowledge clock; data moves only while the clock is
    // low so that no bit is mistaken for a START or STOP.
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--)
        begin
            sda_pull <= !d[i];
            repeat (4) @(posedge core_clk);
            scl <= 1'b1;
            half();
            q[i] = sda_line;
            scl <= 1'b0;
            repeat (2) @(posedge core_clk);
        end
    endtask : xfer
endmodule : i2c_host_model

//--- tb/rtc_init_and_i2c_access_tb.sv
`timescale 1ns/1ps
// ----
// Bench top
// ----
module rtc_init_and_i2c_access_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic osc_running = 1'b0;
    logic [1:0] tick_cnt = 2'h0;
    logic osc_tick;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sda_out, sda_oe, scl, sda_pull, sda_line;
    int errors = 0;
    int checks = 0;
    localparam logic [8:0] AW = {rtc_pkg::SLAVE_ADDR, 2'b01};
    localparam logic [8:0] AR = {rtc_pkg::SLAVE_ADDR, 2'b11};

    // Wired-AND data line with a pull-up; the device pulls low only while enabled.
    assign sda_line = !(sda_pull || (sda_oe && !sda_out));

    // The 250 MHz clock and a crystal tick that runs only while oscillation is on.
    initial
    begin
        forever #2 core_clk = !core_clk;
    end
    // The tick divides the clock by four, so one device second takes 4096 clocks.
    always @(posedge core_clk) if (osc_running) tick_cnt <= tick_cnt + 2'h1;
    assign osc_tick = tick_cnt[1];

    rtc_i2c_core u_dut (.core_clk(core_clk), .rst_n(rst_n), .ce(1'b1),
        .osc_running(osc_running), .osc_tick(osc_tick), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    i2c_host_model u_host (.core_clk(core_clk), .sda_line(sda_line), .scl(scl),
        .sda_pull(sda_pull));

    task automatic summarize;
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    // One APB transfer; the wait for pready is bounded so a dead slave ends the run.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge keeps a following call from driving psel twice in a step.
        @(posedge core_clk);
        if (n >= 50)
        begin
            errors++;
            summarize();
        end
    endtask : apb

    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(nm, x, q);
    endtask : rd

    // A byte as seen on the line, with the acknowledge bit last.
    task automatic tx(input logic [8:0] d, input logic [8:0] x);
        logic [8:0] q;
        u_host.xfer(d, q);
        chk("byte", {23'h0, x}, {23'h0, q});
    endtask : tx

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        u_host.start();
        tx(AW, {AW[8:1], 1'b0});
        tx({i, 1'b1}, {i, 1'b0});
        tx({d, 1'b1}, {d, 1'b0});
        u_host.stop();
        chk("sda_oe", 32'h0, {31'h0, sda_oe});
        chk("sda_out", 32'h0, {31'h0, sda_out});
    endtask : wr

    initial
    begin
        logic [31:0] q;
        logic e;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        u_host.start();
        tx(AR, {AR[8:1], 1'b0});
        tx(9'h1ff, 9'h001);
        u_host.stop();
        rd("status", rtc_pkg::APB_STATUS, 32'h1);
        wr(8'h09, 8'h00);
        rd("status", rtc_pkg::APB_STATUS, 32'h1);
        wr(8'h08, 8'h00);
        osc_running <= 1'b1;
        repeat (8) @(posedge core_clk);
        wr(8'h09, 8'h00);
        rd("status", rtc_pkg::APB_STATUS, 32'h2);
        wr(8'h0b, 8'h00);
        apb(1'b1, rtc_pkg::APB_CMD, 32'h1, q, e);
        rd("status", rtc_pkg::APB_STATUS, 32'h3);
        apb(1'b0, 12'h00c, 32'h0, q, e);
        chk("pslverr", 32'h1, {31'h0, e});
        u_host.start();
        tx({7'h33, 2'b01}, {7'h33, 2'b01});
        u_host.stop();
        u_host.start();
        tx(AW, {AW[8:1], 1'b0});
        tx(9'h007, 9'h006);
        for (int k = 0; k < 5; k++) tx({8'ha1 + 8'(k), 1'b1}, {8'ha1 + 8'(k), 1'b0});
        u_host.stop();
        u_host.start();
        tx(AW, {AW[8:1], 1'b0});
        tx(9'h007, 9'h006);
        u_host.start();
        tx(AR, {AR[8:1], 1'b0});
        for (int k = 0; k < 5; k++) tx({8'hff, k == 4}, {8'ha1 + 8'(k), k == 4});
        u_host.stop();
        wr(8'h0a, 8'h01);
        wr(8'h00, 8'h58);
        repeat (6144) @(posedge core_clk);
        rd("time", rtc_pkg::APB_TIME, 32'h58);
        wr(8'h0a, 8'h00);
        repeat (6144) @(posedge core_clk);
        rd("time", rtc_pkg::APB_TIME, 32'h59);
        repeat (4096) @(posedge core_clk);
        rd("time", rtc_pkg::APB_TIME, 32'h100);
        wr(8'h00, 8'h30);
        repeat (6144) @(posedge core_clk);
        rd("time", rtc_pkg::APB_TIME, 32'h131);
        u_host.start();
        tx(AW, {AW[8:1], 1'b0});
        tx(9'h001, 9'h000);
        repeat (3072) @(posedge core_clk);
        rd("time", rtc_pkg::APB_TIME, 32'h131);
        rd("status", rtc_pkg::APB_STATUS, 32'h1b);
        u_host.stop();
        repeat (4) @(posedge core_clk);
        rd("time", rtc_pkg::APB_TIME, 32'h132);
        summarize();
    end
endmodule : rtc_init_and_i2c_access_tb
